// ===== src/axis_cc_defines.svh
`ifndef AXIS_CC_DEFINES_SVH
`define AXIS_CC_DEFINES_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_CNT1 8'h08
`define OFS_CNT2 8'h0C
`define OFS_CNT3 8'h10
`define OFS_LAT1 8'h14
`define OFS_LAT2 8'h18
`define OFS_LAT3 8'h1C
`define OFS_RING1 8'h20
`define OFS_RING2 8'h24
`define OFS_RING3 8'h28
`define OFS_CMP1 8'h2C
`define OFS_CMP2 8'h30
`define OFS_CMP3 8'h34
`define OFS_CMPCFG 8'h38
`define OFS_STATUS 8'h40
`define OFS_MASK 8'h44
`define OFS_STATE 8'h48

// control register fields
`define CTRL_RING_LSB 0
`define CTRL_SRC2_LSB 4
`define CTRL_SRC3_LSB 6
`define CTRL_SL_EN 9
`define CTRL_SL_DECEL 10
`define CTRL_SYNC_EN 11
`define CTRL_LTC_EN 12
`define CTRL_ORG_EN 13
`define CTRL_CLR_EN 14
`define CTRL_RESET 16'h0000

// command register fields
`define CMD_CLR_LSB 0
`define CMD_LAT_LSB 3

// comparator configuration: 4 bits per comparator
`define CFG_SEL_LSB 0
`define CFG_COND_LSB 2
`define CFG_RESET 12'hFFC

// status bits
`define ST_MATCH_LSB 0
`define ST_PSL 3
`define ST_NSL 4
`define ST_SYNC 5
`define ST_LATCH 6

// clock divider length for the deviation counter source
`define DIV_LEN 4096

`endif

// ===== src/axis_cc_pkg.sv
package axis_cc_pkg;

    typedef enum logic [1:0] {SRC_CMD, SRC_ENC, SRC_PULSER} pos_src_e;

    typedef enum logic [2:0] {DEV_CMD, DEV_ENC, DEV_PULSER, DEV_CLK, DEV_CMD_ENC, DEV_CMD_PULSER,
        DEV_ENC_PULSER} dev_src_e;

    typedef enum logic [1:0] {SEL_CMD_POS, SEL_MECH_POS, SEL_DEV} cnt_sel_e;

    typedef enum logic [1:0] {CMP_EQ, CMP_GE, CMP_LE, CMP_OFF} cmp_cond_e;

    typedef logic signed [2:0] delta_t;

endpackage

// ===== src/step_if.sv
`timescale 1ns/1ps
interface step_if;
    logic up;
    logic dn;
    modport src (output up, output dn);
    modport snk (input up, input dn);
endinterface

// ===== src/phase_decoder.sv
`timescale 1ns/1ps
module phase_decoder
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // raw phase pins
    input wire logic phase_a,
    input wire logic phase_b,
    // decoded count steps
    step_if.src steps
);
    typedef struct packed {
        logic a_m;
        logic b_m;
        logic a_s;
        logic b_s;
        logic a_d;
        logic b_d;
        logic up;
        logic dn;
    } dec_s;

    dec_s st_r;
    dec_s st_nxt;
    logic en;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.a_m = phase_a;
        st_nxt.b_m = phase_b;
        st_nxt.a_s = st_r.a_m;
        st_nxt.b_s = st_r.b_m;
        st_nxt.a_d = st_r.a_s;
        st_nxt.b_d = st_r.b_s;
        // 4x decode; a double change is a glitch and is dropped
        en = st_r.a_s ^ st_r.a_d ^ st_r.b_s ^ st_r.b_d;
        st_nxt.up = en & (st_r.a_s ^ st_r.b_d);
        st_nxt.dn = en & ~(st_r.a_s ^ st_r.b_d);
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign steps.up = st_r.up;
    assign steps.dn = st_r.dn;
endmodule

// ===== src/axis_counter_comparator.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "axis_cc_defines.svh"
// Functional notes
// - commanded-position counter, 28 bits, counts only emitted command pulses.
// - mechanical-position counter, 28 bits, source command, encoder or pulser.
// - 16-bit deviation or general counter, can drive the sync output.
// - 16-bit source: command, encoder, pulser, clock/4096, or pairwise differences.
// - every counter clears by software command or the clear input.
// - every counter latches on command, latch input or origin sensor.
// - every counter has a ring mode wrapping within a programmed range.
// - three comparators compare a programmed target with a counter.
// - each comparator selects commanded, mechanical or deviation counter.
// - comparators 1 and 2 may act as positive and negative soft limits.
// - entering a soft limit halts pulses, immediately or by deceleration.
// - after a soft-limit stop only opposite-direction motion is permitted.
// - sync pulse emitted repeatedly at a programmed constant interval.
module axis_counter_comparator
    import axis_cc_pkg::*;
#(
    parameter int POS_W = 28,
    parameter int DEV_W = 16,
    parameter int DIV_W = 12
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // command pulses from the axis pulse generator
    input wire logic cmd_pulse,
    input wire logic cmd_dir_pos,
    // phase pins
    input wire logic encoder_phase_a,
    input wire logic encoder_phase_b,
    input wire logic pulser_phase_a,
    input wire logic pulser_phase_b,
    // mechanical and control pins
    input wire logic counter_clear_input,
    input wire logic latch_input,
    input wire logic origin_sensor_input,
    // limit and motion outputs
    output logic positive_soft_limit,
    output logic negative_soft_limit,
    output logic halt_now,
    output logic halt_decel,
    output logic inhibit_pos,
    output logic inhibit_neg,
    output logic sync_out,
    output logic irq
);
    typedef struct packed {
        logic [POS_W-1:0] cnt1;
        logic [POS_W-1:0] cnt2;
        logic [DEV_W-1:0] cnt3;
        logic [POS_W-1:0] lat1;
        logic [POS_W-1:0] lat2;
        logic [DEV_W-1:0] lat3;
        logic [POS_W-1:0] ring1;
        logic [POS_W-1:0] ring2;
        logic [DEV_W-1:0] ring3;
        logic [2:0][POS_W-1:0] cmpv;
        logic [15:0] ctrl;
        logic [11:0] cmpcfg;
        logic [6:0] status;
        logic [6:0] mask;
        logic [DIV_W-1:0] div;
        logic [2:0] hit_d;
        logic psl;
        logic nsl;
        logic inh_pos;
        logic inh_neg;
        logic last_pos;
        logic clr_m;
        logic clr_s;
        logic clr_d;
        logic ltc_m;
        logic ltc_s;
        logic ltc_d;
        logic org_m;
        logic org_s;
        logic org_d;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic halt_now;
        logic halt_decel;
        logic sync_out;
        logic irq;
    } cc_s;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(`DIV_LEN - 1);

    cc_s st_r;
    cc_s st_nxt;

    step_if enc_steps ();
    step_if pul_steps ();

    phase_decoder u_enc
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .phase_a(encoder_phase_a),
        .phase_b(encoder_phase_b),
        .steps(enc_steps.src)
    );

    phase_decoder u_pul
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .phase_a(pulser_phase_a),
        .phase_b(pulser_phase_b),
        .steps(pul_steps.src)
    );

    function automatic delta_t step_of(input logic up, input logic dn);
        delta_t d;
        d = 3'sd0;
        if (up && !dn)
            d = 3'sd1;
        else if (dn && !up)
            d = -3'sd1;
        return d;
    endfunction

    // ring wraps within 0..top; without ring the count wraps at full width
    function automatic logic [POS_W-1:0] ring_step(input logic [POS_W-1:0] v, input delta_t d,
        input logic ring, input logic [POS_W-1:0] top);
        logic signed [POS_W+1:0] s;
        logic signed [POS_W+1:0] t;
        s = $signed({2'b00, v}) + (POS_W+2)'(d);
        t = $signed({2'b00, top});
        if (ring && s > t)
            s = s - t - (POS_W+2)'(1);
        else if (ring && s < 0)
            s = s + t + (POS_W+2)'(1);
        return s[POS_W-1:0];
    endfunction

    function automatic logic cmp_hit(input logic signed [POS_W-1:0] v, input logic signed [POS_W-1:0] t,
        input cmp_cond_e c);
        logic h;
        h = 1'b0;
        unique case (c)
            CMP_EQ: h = (v == t);
            CMP_GE: h = (v >= t);
            CMP_LE: h = (v <= t);
            CMP_OFF: h = 1'b0;
        endcase
        return h;
    endfunction

    logic wr;
    logic rd;
    delta_t d_cmd;
    delta_t d_enc;
    delta_t d_pul;
    delta_t d_clk;
    delta_t d2;
    delta_t d3;
    logic [2:0] clr;
    logic [2:0] lat;
    logic [2:0] hit;
    logic [6:0] ev;
    logic [6:0] w1c;
    logic psl_now;
    logic nsl_now;
    logic signed [POS_W-1:0] v;
    logic [31:0] rdata;
    logic rerr;

    always_comb
    begin
        st_nxt = st_r;
        v = '0;
        ev = '0;
        w1c = '0;
        hit = '0;
        rdata = 32'h0000_0000;
        rerr = 1'b0;
        // pins pass two flip-flops before use
        st_nxt.clr_m = counter_clear_input;
        st_nxt.clr_s = st_r.clr_m;
        st_nxt.clr_d = st_r.clr_s;
        st_nxt.ltc_m = latch_input;
        st_nxt.ltc_s = st_r.ltc_m;
        st_nxt.ltc_d = st_r.ltc_s;
        st_nxt.org_m = origin_sensor_input;
        st_nxt.org_s = st_r.org_m;
        st_nxt.org_d = st_r.org_s;

        wr = psel && penable && st_r.pready && pwrite;
        rd = psel && !penable && !pwrite;

        d_cmd = cmd_pulse ? (cmd_dir_pos ? 3'sd1 : -3'sd1) : 3'sd0;
        d_enc = step_of(enc_steps.up, enc_steps.dn);
        d_pul = step_of(pul_steps.up, pul_steps.dn);
        st_nxt.div = st_r.div + DIV_W'(1);
        d_clk = (st_r.div == DIV_LAST) ? 3'sd1 : 3'sd0;
        if (cmd_pulse)
            st_nxt.last_pos = cmd_dir_pos;

        unique case (pos_src_e'(st_r.ctrl[`CTRL_SRC2_LSB +: 2]))
            SRC_CMD: d2 = d_cmd;
            SRC_ENC: d2 = d_enc;
            SRC_PULSER: d2 = d_pul;
            default: d2 = 3'sd0;
        endcase
        unique case (dev_src_e'(st_r.ctrl[`CTRL_SRC3_LSB +: 3]))
            DEV_CMD: d3 = d_cmd;
            DEV_ENC: d3 = d_enc;
            DEV_PULSER: d3 = d_pul;
            DEV_CLK: d3 = d_clk;
            DEV_CMD_ENC: d3 = d_cmd - d_enc;
            DEV_CMD_PULSER: d3 = d_cmd - d_pul;
            DEV_ENC_PULSER: d3 = d_enc - d_pul;
            default: d3 = 3'sd0;
        endcase

        st_nxt.cnt1 = ring_step(st_r.cnt1, d_cmd, st_r.ctrl[`CTRL_RING_LSB], st_r.ring1);
        st_nxt.cnt2 = ring_step(st_r.cnt2, d2, st_r.ctrl[`CTRL_RING_LSB+1], st_r.ring2);
        st_nxt.cnt3 = DEV_W'(ring_step(POS_W'(st_r.cnt3), d3, st_r.ctrl[`CTRL_RING_LSB+2],
            POS_W'(st_r.ring3)));

        // sync pulse each time the 16-bit ring wraps back to zero
        ev[`ST_SYNC] = st_r.ctrl[`CTRL_SYNC_EN] && st_r.ctrl[`CTRL_RING_LSB+2] && d3 > 0
            && st_nxt.cnt3 == '0 && st_r.cnt3 != '0;
        st_nxt.sync_out = ev[`ST_SYNC];

        clr = {3{st_r.ctrl[`CTRL_CLR_EN] && st_r.clr_s && !st_r.clr_d}};
        lat = {3{(st_r.ctrl[`CTRL_LTC_EN] && st_r.ltc_s && !st_r.ltc_d)
            || (st_r.ctrl[`CTRL_ORG_EN] && st_r.org_s && !st_r.org_d)}};
        if (wr && paddr == `OFS_CMD)
        begin
            clr = clr | pwdata[`CMD_CLR_LSB +: 3];
            lat = lat | pwdata[`CMD_LAT_LSB +: 3];
        end
        // latch captures the count before this cycle's clear
        if (lat[0])
            st_nxt.lat1 = st_r.cnt1;
        if (lat[1])
            st_nxt.lat2 = st_r.cnt2;
        if (lat[2])
            st_nxt.lat3 = st_r.cnt3;
        ev[`ST_LATCH] = |lat;
        if (clr[0])
            st_nxt.cnt1 = '0;
        if (clr[1])
            st_nxt.cnt2 = '0;
        if (clr[2])
            st_nxt.cnt3 = '0;

        for (int i = 0; i < 3; i++)
        begin
            unique case (cnt_sel_e'(st_r.cmpcfg[4*i+`CFG_SEL_LSB +: 2]))
                SEL_CMD_POS: v = st_r.cnt1;
                SEL_MECH_POS: v = st_r.cnt2;
                SEL_DEV: v = POS_W'($signed(st_r.cnt3));
                default: v = '0;
            endcase
            hit[i] = cmp_hit(v, st_r.cmpv[i], cmp_cond_e'(st_r.cmpcfg[4*i+`CFG_COND_LSB +: 2]));
        end
        st_nxt.hit_d = hit;
        ev[`ST_MATCH_LSB +: 3] = hit & ~st_r.hit_d;

        // soft-limit mode fixes comparators 1 and 2 to >= and <=
        psl_now = 1'b0;
        nsl_now = 1'b0;
        if (st_r.ctrl[`CTRL_SL_EN])
        begin
            unique case (cnt_sel_e'(st_r.cmpcfg[`CFG_SEL_LSB +: 2]))
                SEL_CMD_POS: v = st_r.cnt1;
                SEL_MECH_POS: v = st_r.cnt2;
                SEL_DEV: v = POS_W'($signed(st_r.cnt3));
                default: v = '0;
            endcase
            psl_now = cmp_hit(v, st_r.cmpv[0], CMP_GE);
            unique case (cnt_sel_e'(st_r.cmpcfg[4+`CFG_SEL_LSB +: 2]))
                SEL_CMD_POS: v = st_r.cnt1;
                SEL_MECH_POS: v = st_r.cnt2;
                SEL_DEV: v = POS_W'($signed(st_r.cnt3));
                default: v = '0;
            endcase
            nsl_now = cmp_hit(v, st_r.cmpv[1], CMP_LE);
        end
        st_nxt.psl = psl_now;
        st_nxt.nsl = nsl_now;
        ev[`ST_PSL] = psl_now && !st_r.psl && st_r.last_pos;
        ev[`ST_NSL] = nsl_now && !st_r.nsl && !st_r.last_pos;
        st_nxt.halt_now = (ev[`ST_PSL] || ev[`ST_NSL]) && !st_r.ctrl[`CTRL_SL_DECEL];
        st_nxt.halt_decel = (ev[`ST_PSL] || ev[`ST_NSL]) && st_r.ctrl[`CTRL_SL_DECEL];
        // inhibit holds while the axis stays inside the limit range
        if (ev[`ST_PSL])
            st_nxt.inh_pos = 1'b1;
        else if (!psl_now)
            st_nxt.inh_pos = 1'b0;
        if (ev[`ST_NSL])
            st_nxt.inh_neg = 1'b1;
        else if (!nsl_now)
            st_nxt.inh_neg = 1'b0;

        if (wr)
        begin
            unique case (paddr)
                `OFS_CTRL: st_nxt.ctrl = pwdata[15:0];
                `OFS_CNT1: st_nxt.cnt1 = pwdata[POS_W-1:0];
                `OFS_CNT2: st_nxt.cnt2 = pwdata[POS_W-1:0];
                `OFS_CNT3: st_nxt.cnt3 = pwdata[DEV_W-1:0];
                `OFS_RING1: st_nxt.ring1 = pwdata[POS_W-1:0];
                `OFS_RING2: st_nxt.ring2 = pwdata[POS_W-1:0];
                `OFS_RING3: st_nxt.ring3 = pwdata[DEV_W-1:0];
                `OFS_CMP1: st_nxt.cmpv[0] = pwdata[POS_W-1:0];
                `OFS_CMP2: st_nxt.cmpv[1] = pwdata[POS_W-1:0];
                `OFS_CMP3: st_nxt.cmpv[2] = pwdata[POS_W-1:0];
                `OFS_CMPCFG: st_nxt.cmpcfg = pwdata[11:0];
                `OFS_STATUS: w1c = pwdata[6:0];
                `OFS_MASK: st_nxt.mask = pwdata[6:0];
                default: ;
            endcase
        end
        // a new event outweighs a clear in the same cycle
        st_nxt.status = (st_r.status & ~w1c) | ev;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);

        unique case (paddr)
            `OFS_CTRL: rdata = {16'h0000, st_r.ctrl};
            `OFS_CMD: rdata = 32'h0000_0000;
            `OFS_CNT1: rdata = 32'(st_r.cnt1);
            `OFS_CNT2: rdata = 32'(st_r.cnt2);
            `OFS_CNT3: rdata = 32'(st_r.cnt3);
            `OFS_LAT1: rdata = 32'(st_r.lat1);
            `OFS_LAT2: rdata = 32'(st_r.lat2);
            `OFS_LAT3: rdata = 32'(st_r.lat3);
            `OFS_RING1: rdata = 32'(st_r.ring1);
            `OFS_RING2: rdata = 32'(st_r.ring2);
            `OFS_RING3: rdata = 32'(st_r.ring3);
            `OFS_CMP1: rdata = 32'(st_r.cmpv[0]);
            `OFS_CMP2: rdata = 32'(st_r.cmpv[1]);
            `OFS_CMP3: rdata = 32'(st_r.cmpv[2]);
            `OFS_CMPCFG: rdata = {20'h00000, st_r.cmpcfg};
            `OFS_STATUS: rdata = {25'h0000000, st_r.status};
            `OFS_MASK: rdata = {25'h0000000, st_r.mask};
            `OFS_STATE: rdata = {27'h0000000, st_r.last_pos, st_r.inh_neg, st_r.inh_pos, st_r.nsl, st_r.psl};
            default: rerr = 1'b1;
        endcase

        // one wait-free access phase: ready rises the cycle after setup
        st_nxt.pready = psel && !penable;
        st_nxt.pslverr = psel && !penable && rerr;
        if (rd)
            st_nxt.prdata = rdata;
        else if (psel && !penable)
            st_nxt.prdata = 32'h0000_0000;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_r <= '0;
            st_r.ctrl <= `CTRL_RESET;
            st_r.cmpcfg <= `CFG_RESET;
        end
        else
            st_r <= st_nxt;
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign positive_soft_limit = st_r.psl;
    assign negative_soft_limit = st_r.nsl;
    assign halt_now = st_r.halt_now;
    assign halt_decel = st_r.halt_decel;
    assign inhibit_pos = st_r.inh_pos;
    assign inhibit_neg = st_r.inh_neg;
    assign sync_out = st_r.sync_out;
    assign irq = st_r.irq;
endmodule

// ===== testbench/axis_cc_props.sv
`timescale 1ns/1ps
module axis_cc_props
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // motion outputs
    input wire logic positive_soft_limit,
    input wire logic negative_soft_limit,
    input wire logic halt_now,
    input wire logic halt_decel,
    input wire logic inhibit_pos,
    input wire logic inhibit_neg,
    input wire logic sync_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence halt_s;
        halt_now || halt_decel;
    endsequence
    ready_after_setup_a: assert property (apb_setup_s |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    err_data_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response without ready or with data");
    halt_single_a: assert property (halt_s |=> !halt_now && !halt_decel)
        else $error("halt request longer than one cycle");
    halt_excl_a: assert property (!(halt_now && halt_decel))
        else $error("both halt kinds at once");
    halt_cause_a: assert property (halt_s |-> positive_soft_limit || negative_soft_limit)
        else $error("halt outside a limit range");
    inh_pos_enter_a: assert property ($rose(inhibit_pos) |-> positive_soft_limit)
        else $error("positive inhibit without positive limit");
    inh_pos_leave_a: assert property ($fell(positive_soft_limit) |-> ##[0:2] !inhibit_pos)
        else $error("positive inhibit kept after leaving limit");
    inh_neg_enter_a: assert property ($rose(inhibit_neg) |-> negative_soft_limit)
        else $error("negative inhibit without negative limit");
    sync_single_a: assert property (sync_out |=> !sync_out)
        else $error("sync pulse longer than one cycle");
endmodule

// ===== testbench/axis_partner.sv
`timescale 1ns/1ps
module axis_partner
(
    // clock
    input wire logic ref_clk,
    // pulse generator
    output logic cmd_pulse,
    output logic cmd_dir_pos,
    // phase pins
    output logic encoder_phase_a,
    output logic encoder_phase_b,
    output logic pulser_phase_a,
    output logic pulser_phase_b
);
    initial
    begin
        {cmd_pulse, cmd_dir_pos} = 2'b00;
        {encoder_phase_a, encoder_phase_b, pulser_phase_a, pulser_phase_b} = 4'h0;
    end
    task automatic cmd_steps(input int n, input logic dir);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            cmd_pulse <= 1'b1;
            cmd_dir_pos <= dir;
            @(posedge ref_clk);
            cmd_pulse <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
    endtask
    // gray steps held 6 cycles so the 2-flop sync sees each edge
    task automatic quad(input logic pulser, input int cycles, input logic fwd);
        logic [1:0] ph;
        for (int i = 0; i < 4 * cycles; i++)
        begin
            ph = pulser ? {pulser_phase_a, pulser_phase_b} : {encoder_phase_a, encoder_phase_b};
            ph = fwd ? {~ph[0], ph[1]} : {ph[0], ~ph[1]};
            @(posedge ref_clk);
            if (pulser)
                {pulser_phase_a, pulser_phase_b} <= ph;
            else
                {encoder_phase_a, encoder_phase_b} <= ph;
            repeat (5) @(posedge ref_clk);
        end
    endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`include "axis_cc_defines.svh"
module testbench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, cmd_pulse, cmd_dir_pos;
    logic encoder_phase_a, encoder_phase_b, pulser_phase_a, pulser_phase_b;
    logic counter_clear_input = 1'b0, latch_input = 1'b0, origin_sensor_input = 1'b0;
    logic positive_soft_limit, negative_soft_limit, halt_now, halt_decel;
    logic inhibit_pos, inhibit_neg, sync_out, irq;
    int err_total = 0, checks = 0, n_now = 0, n_decel = 0, n_sync = 0;

    always #2 ref_clk = ~ref_clk;

    axis_counter_comparator dut_u (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_pulse(cmd_pulse), .cmd_dir_pos(cmd_dir_pos),
        .encoder_phase_a(encoder_phase_a), .encoder_phase_b(encoder_phase_b),
        .pulser_phase_a(pulser_phase_a), .pulser_phase_b(pulser_phase_b),
        .counter_clear_input(counter_clear_input), .latch_input(latch_input),
        .origin_sensor_input(origin_sensor_input), .positive_soft_limit(positive_soft_limit),
        .negative_soft_limit(negative_soft_limit), .halt_now(halt_now), .halt_decel(halt_decel),
        .inhibit_pos(inhibit_pos), .inhibit_neg(inhibit_neg), .sync_out(sync_out), .irq(irq));

    axis_partner partner_u (.ref_clk(ref_clk), .cmd_pulse(cmd_pulse), .cmd_dir_pos(cmd_dir_pos),
        .encoder_phase_a(encoder_phase_a), .encoder_phase_b(encoder_phase_b),
        .pulser_phase_a(pulser_phase_a), .pulser_phase_b(pulser_phase_b));

    always @(posedge ref_clk)
    begin
        n_now += (halt_now === 1'b1);
        n_decel += (halt_decel === 1'b1);
        n_sync += (sync_out === 1'b1);
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            err_total++;
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        repeat (4) @(posedge ref_clk);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic pin(input int which);
        @(posedge ref_clk);
        {counter_clear_input, latch_input, origin_sensor_input} <= 3'b100 >> which;
        repeat (4) @(posedge ref_clk);
        {counter_clear_input, latch_input, origin_sensor_input} <= 3'b000;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        err_total++;
        end_of_test();
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rchk("ctrl reset", `OFS_CTRL, 32'h0);
        rchk("cmpcfg reset", `OFS_CMPCFG, 32'h0000_0FFC);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        wr(`OFS_CMD, 32'h7);
        partner_u.cmd_steps(5, 1'b1);
        partner_u.cmd_steps(2, 1'b0);
        rchk("cnt1 net count", `OFS_CNT1, 32'h3);
        wr(`OFS_CNT1, 32'h0);
        wr(`OFS_RING1, 32'h3);
        wr(`OFS_CTRL, 32'h1);
        partner_u.cmd_steps(5, 1'b1);
        rchk("ring wrap up", `OFS_CNT1, 32'h1);
        partner_u.cmd_steps(2, 1'b0);
        rchk("ring wrap down", `OFS_CNT1, 32'h3);
        $display("test counters and ring done");
        wr(`OFS_CTRL, 32'h110);
        wr(`OFS_CMD, 32'h7);
        partner_u.cmd_steps(3, 1'b1);
        partner_u.quad(1'b0, 2, 1'b1);
        rchk("cnt1 ignores encoder", `OFS_CNT1, 32'h3);
        rchk("cnt2 encoder", `OFS_CNT2, 32'h8);
        rchk("cnt3 deviation", `OFS_CNT3, 32'hFFFB);
        wr(`OFS_CTRL, 32'h1A0);
        wr(`OFS_CMD, 32'h7);
        partner_u.quad(1'b1, 1, 1'b0);
        rchk("cnt2 pulser down", `OFS_CNT2, 32'h0FFF_FFFC);
        rchk("cnt3 enc minus pulser", `OFS_CNT3, 32'h4);
        wr(`OFS_CTRL, 32'hC0);
        wr(`OFS_CMD, 32'h4);
        repeat (8200) @(posedge ref_clk);
        apb(1'b0, `OFS_CNT3, 32'h0);
        chk("cnt3 divided clock", 32'h1, {31'h0, rd === 32'h2 || rd === 32'h3});
        $display("test count sources done");
        wr(`OFS_CTRL, 32'h4010);
        wr(`OFS_CNT1, 32'h5);
        wr(`OFS_CNT2, 32'h6);
        pin(0);
        rchk("pin clear cnt1", `OFS_CNT1, 32'h0);
        rchk("pin clear cnt2", `OFS_CNT2, 32'h0);
        wr(`OFS_CTRL, 32'h3000);
        wr(`OFS_CNT1, 32'h7);
        wr(`OFS_CMD, 32'h8);
        rchk("soft latch", `OFS_LAT1, 32'h7);
        wr(`OFS_CNT2, 32'h9);
        pin(1);
        rchk("pin latch", `OFS_LAT2, 32'h9);
        wr(`OFS_CNT3, 32'h12);
        pin(2);
        rchk("origin latch", `OFS_LAT3, 32'h12);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("latch flag", 32'h1, {31'h0, rd[6]});
        $display("test clear and latch done");
        wr(`OFS_CTRL, 32'h1C0);
        wr(`OFS_CMPCFG, 32'hA50);
        wr(`OFS_CMP1, 32'h2);
        wr(`OFS_CMP2, 32'h4);
        wr(`OFS_CMP3, 32'h0FFF_FFFF);
        wr(`OFS_CMD, 32'h7);
        wr(`OFS_STATUS, 32'h7F);
        partner_u.cmd_steps(3, 1'b1);
        rchk("match eq sticky", `OFS_STATUS, 32'h1);
        partner_u.cmd_steps(1, 1'b1);
        rchk("match ge", `OFS_STATUS, 32'h3);
        wr(`OFS_CMP3, 32'h0);
        rchk("match le", `OFS_STATUS, 32'h7);
        wr(`OFS_STATUS, 32'h1);
        rchk("match ack", `OFS_STATUS, 32'h6);
        $display("test comparators done");
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_CMPCFG, 32'hCCC);
        wr(`OFS_CNT1, 32'h5);
        wr(`OFS_CMP1, 32'h8);
        wr(`OFS_CMP2, 32'h2);
        wr(`OFS_STATUS, 32'h7F);
        wr(`OFS_CTRL, 32'h200);
        partner_u.cmd_steps(3, 1'b1);
        rchk("positive limit state", `OFS_STATE, 32'h15);
        chk("immediate halts", 32'h1, n_now);
        rchk("limit status", `OFS_STATUS, 32'h8);
        wr(`OFS_MASK, 32'h8);
        rchk("irq unmasked", `OFS_MASK, 32'h8);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`OFS_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`OFS_MASK, 32'h8);
        wr(`OFS_STATUS, 32'h8);
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        partner_u.cmd_steps(1, 1'b0);
        rchk("limit left", `OFS_STATE, 32'h0);
        wr(`OFS_CTRL, 32'h600);
        partner_u.cmd_steps(5, 1'b0);
        rchk("negative limit state", `OFS_STATE, 32'hA);
        chk("decel halts", 32'h1, n_decel);
        $display("test soft limits done");
        wr(`OFS_CTRL, 32'h804);
        wr(`OFS_RING3, 32'h2);
        wr(`OFS_CMD, 32'h4);
        wr(`OFS_STATUS, 32'h7F);
        n_sync = 0;
        partner_u.cmd_steps(6, 1'b1);
        chk("sync pulses", 32'h2, n_sync);
        rchk("sync flag", `OFS_STATUS, 32'h20);
        $display("test sync done");
        end_of_test();
    end
endmodule

bind axis_counter_comparator axis_cc_props props_u (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .positive_soft_limit(positive_soft_limit), .negative_soft_limit(negative_soft_limit),
    .halt_now(halt_now), .halt_decel(halt_decel), .inhibit_pos(inhibit_pos),
    .inhibit_neg(inhibit_neg), .sync_out(sync_out));
